// >>> rtl/jfr_pkg.sv
/*
 package for the fifo readback control block: instruction codes, widths, reset values.
 assumes a three-bit virtual instruction register driven by the jtag hub.
*/
`default_nettype none
package jfr_pkg;
	localparam int unsigned JFR_IR_W = 3; // virtual instruction width
	localparam int unsigned JFR_DATA_W = 8; // fifo word width
	localparam logic [2:0] JFR_IR_ENQ = 3'h1; // enqueue instruction
	localparam logic [2:0] JFR_IR_DEQ = 3'h2; // dequeue instruction
	localparam logic [2:0] JFR_IR_DRAIN = 3'h3; // drain instruction
	localparam logic [7:0] JFR_WORD_RST = 8'h00; // chain value after reset
	localparam int unsigned JFR_SYNC_STAGES = 2; // flip-flops per crossing
	typedef logic [JFR_DATA_W-1:0] jfr_word_t; // one fifo word
	typedef enum logic [1:0] {
		JFR_IDLE = 2'b00,
		JFR_REQ = 2'b01,
		JFR_WAIT = 2'b11
	} jfr_rd_e; // read-side pop sequencer
endpackage
`default_nettype wire

// >>> rtl/jfr_buf_if.sv
/*
 interface carrying the fifo word stream between the read side and the buffer.
 assumes both ends sit on i_clk.
*/
`default_nettype none
interface jfr_buf_if;
	import jfr_pkg::*;
	logic valid; // word offered
	logic ready; // word accepted
	jfr_word_t data; // word
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> rtl/jfr_skid_buf.sv
/*
 two-entry buffer with valid and ready on both sides.
 assumes a single clock and asynchronous high reset.
*/
`default_nettype none
module jfr_skid_buf
	import jfr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	jfr_buf_if.snk in_if,
	jfr_buf_if.src out_if
);
	import jfr_pkg::*;
	jfr_word_t mem_q [2]; // storage
	jfr_word_t mem_d [2];
	logic [1:0] cnt_q, cnt_d; // entries held
	logic wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d; // slot pointers
	logic push, pop;

	// next-state of the buffer
	always_comb begin
		push = in_if.valid && (cnt_q != 2'h2);
		pop = (cnt_q != 2'h0) && out_if.ready;
		mem_d = mem_q;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		if (push) begin
			mem_d[wr_ptr_q] = in_if.data;
			wr_ptr_d = ~wr_ptr_q;
		end
		if (pop) begin
			rd_ptr_d = ~rd_ptr_q;
		end
		cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	end

	// register the buffer
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			mem_q[0] <= JFR_WORD_RST;
			mem_q[1] <= JFR_WORD_RST;
			cnt_q <= 2'h0;
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
		end else begin
			mem_q <= mem_d;
			cnt_q <= cnt_d;
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
		end
	end

	assign in_if.ready = (cnt_q != 2'h2); // honest full
	assign out_if.valid = (cnt_q != 2'h0); // honest empty
	assign out_if.data = mem_q[rd_ptr_q];
endmodule
`default_nettype wire

// >>> rtl/jfr_top.sv
/*
 fifo readback control: decodes dequeue and drain from the virtual instruction,
 pops fifo words in the read clock domain, and shifts them out on the tck chain.
 assumes a dual-clock fifo in normal read mode, with data on i_rd_data one cycle after a pop,
 and a jtag hub supplying tck, tdi, ir and the virtual state indications.
*/
// Function
// - dequeue selects readback chain onto tdo
// - one fifo read pulse per dequeue, none while the fifo is empty
// - capture state loads chain from word
// - shift state shifts chain toward tdo
// - drain holds read request until empty
// - drain selects one-bit bypass register
// - three-bit ir, distinct instruction codes
// - capture on rising, update on falling
`default_nettype none
module jfr_top
	import jfr_pkg::*;
(
	input wire logic i_clk, // fifo read clock
	input wire logic i_reset,
	input wire logic i_tck, // link clock
	input wire logic i_tdi,
	input wire logic [jfr_pkg::JFR_IR_W-1:0] i_ir, // virtual instruction
	input wire logic i_vs_cdr, // virtual capture-data
	input wire logic i_vs_sdr, // virtual shift-data
	input wire logic i_vs_uir, // virtual update-instruction
	input wire logic i_rd_empty, // fifo empty, read domain
	input wire jfr_pkg::jfr_word_t i_rd_data, // fifo output word
	output logic o_tdo,
	output logic o_rd_req // fifo read request
);
	import jfr_pkg::*;

	// ---- tck domain ----
	logic deq_tgl_q, deq_tgl_d; // event toggle per dequeue
	logic drain_q, drain_d; // drain level
	logic [JFR_DATA_W-1:0] chain_q, chain_d; // readback chain
	logic byp_q, byp_d; // bypass bit
	logic tdo_d;
	jfr_word_t word_hold_tck; // stable word from read side

	// instruction compare shared by decode and chain select
	function automatic logic ir_is(input logic [JFR_IR_W-1:0] ir, input logic [JFR_IR_W-1:0] code);
		return ir == code;
	endfunction

	// update-instruction decode: hold registers load on falling tck,
	// so nothing depends on tck running on after the update state
	always_comb begin
		deq_tgl_d = deq_tgl_q;
		drain_d = drain_q;
		if (i_vs_uir) begin
			drain_d = ir_is(i_ir, JFR_IR_DRAIN);
			if (ir_is(i_ir, JFR_IR_DEQ)) begin
				deq_tgl_d = ~deq_tgl_q;
			end
		end
	end
	always_ff @(negedge i_tck or posedge i_reset) begin
		if (i_reset) begin
			deq_tgl_q <= 1'b0;
			drain_q <= 1'b0;
		end else begin
			deq_tgl_q <= deq_tgl_d;
			drain_q <= drain_d;
		end
	end

	// chain, bypass and tdo select on rising tck
	always_comb begin
		chain_d = chain_q;
		byp_d = byp_q;
		tdo_d = byp_q; // bypass unless dequeue
		if (ir_is(i_ir, JFR_IR_DEQ)) begin
			tdo_d = chain_q[0];
			if (i_vs_cdr) chain_d = word_hold_tck;
			else if (i_vs_sdr) chain_d = {i_tdi, chain_q[JFR_DATA_W-1:1]};
		end else begin
			if (i_vs_sdr) byp_d = i_tdi;
			if (i_vs_cdr) byp_d = 1'b0; // capture loads zero
		end
	end
	always_ff @(posedge i_tck or posedge i_reset) begin
		if (i_reset) begin
			chain_q <= JFR_WORD_RST;
			byp_q <= 1'b0;
			o_tdo <= 1'b0;
		end else begin
			chain_q <= chain_d;
			byp_q <= byp_d;
			o_tdo <= tdo_d;
		end
	end

	// ---- read clock domain ----
	logic [JFR_SYNC_STAGES-1:0] tgl_sync_q; // dequeue toggle synchroniser
	logic [JFR_SYNC_STAGES-1:0] drn_sync_q; // drain level synchroniser
	logic tgl_seen_q, tgl_seen_d;
	logic [1:0] empty_sync_q; // empty could be write-domain derived
	jfr_rd_e st_q, st_d;
	logic rd_req_d;
	logic deq_evt;
	jfr_word_t word_q, word_d; // popped word held for tck capture
	jfr_buf_if bin ();
	jfr_buf_if bout ();

	// crossings into read clock
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			tgl_sync_q <= '0;
			drn_sync_q <= '0;
			empty_sync_q <= 2'h3;
		end else begin
			tgl_sync_q <= {tgl_sync_q[0], deq_tgl_q};
			drn_sync_q <= {drn_sync_q[0], drain_q};
			empty_sync_q <= {empty_sync_q[0], i_rd_empty};
		end
	end

	// pop sequencer: one pulse per dequeue unless empty, level while draining
	always_comb begin
		deq_evt = tgl_sync_q[1] ^ tgl_seen_q;
		tgl_seen_d = tgl_sync_q[1];
		st_d = st_q;
		rd_req_d = 1'b0;
		bin.valid = 1'b0;
		bin.data = i_rd_data;
		case (st_q)
			JFR_IDLE: begin
				if (deq_evt && !empty_sync_q[1]) begin
					rd_req_d = 1'b1;
					st_d = JFR_REQ;
				end else if (drn_sync_q[1] && !empty_sync_q[1] && bin.ready) begin
					rd_req_d = !i_rd_empty;
				end
			end
			JFR_REQ: begin
				st_d = JFR_WAIT;
			end
			JFR_WAIT: begin
				bin.valid = 1'b1; // word now at the fifo output
				if (bin.ready) st_d = JFR_IDLE;
			end
			default: st_d = JFR_IDLE;
		endcase
	end
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_q <= JFR_IDLE;
			tgl_seen_q <= 1'b0;
			o_rd_req <= 1'b0;
		end else begin
			st_q <= st_d;
			tgl_seen_q <= tgl_seen_d;
			o_rd_req <= rd_req_d;
		end
	end

	// buffer stands between fifo word and the readback holding register
	jfr_skid_buf u_buf (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.in_if(bin),
		.out_if(bout)
	);

	// holding register drains the buffer; stable long before a capture
	always_comb begin
		bout.ready = 1'b1;
		word_d = bout.valid ? bout.data : word_q;
	end
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) word_q <= JFR_WORD_RST;
		else word_q <= word_d;
	end

	// quasi-static word into tck: settles a few clk after the pop, long before
	// the host can reach capture-data, so no per-bit synchroniser is needed
	assign word_hold_tck = word_q;

	// ---- checks ----
	property p_one_pulse;
		@(posedge i_clk) disable iff (i_reset)
		(st_q == JFR_IDLE && deq_evt && !empty_sync_q[1]) |=> o_rd_req ##1 !o_rd_req;
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("dequeue read not single pulse");
	property p_drain_stop;
		@(posedge i_clk) disable iff (i_reset)
		(!drn_sync_q[1] && st_q == JFR_IDLE && !deq_evt) |=> !o_rd_req;
	endproperty
	a_drain_stop: assert property (p_drain_stop) else $error("read request without drain");
	property p_shift;
		@(posedge i_tck) disable iff (i_reset)
		(i_ir == JFR_IR_DEQ && i_vs_sdr && !i_vs_cdr) |=> chain_q[JFR_DATA_W-2:0] == $past(chain_q[JFR_DATA_W-1:1]);
	endproperty
	a_shift: assert property (p_shift) else $error("chain did not shift");
	property p_capture;
		@(posedge i_tck) disable iff (i_reset)
		(i_ir == JFR_IR_DEQ && i_vs_cdr) |=> chain_q == $past(word_hold_tck);
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed word");
	property p_bypass;
		@(posedge i_tck) disable iff (i_reset)
		(i_ir == JFR_IR_DRAIN && i_vs_sdr) |=> byp_q == $past(i_tdi);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass bit wrong");
	property p_route;
		@(posedge i_tck) disable iff (i_reset)
		(i_ir == JFR_IR_DEQ) |=> o_tdo == $past(chain_q[0]);
	endproperty
	a_route: assert property (p_route) else $error("tdo not from chain");
	property p_drain_dec;
		@(negedge i_tck) disable iff (i_reset)
		(i_vs_uir && i_ir == JFR_IR_DRAIN) |=> drain_q;
	endproperty
	a_drain_dec: assert property (p_drain_dec) else $error("drain not decoded");
	property p_deq_toggle;
		@(negedge i_tck) disable iff (i_reset)
		(i_vs_uir && i_ir == JFR_IR_DEQ) |=> deq_tgl_q != $past(deq_tgl_q);
	endproperty
	a_deq_toggle: assert property (p_deq_toggle) else $error("dequeue not taken on update");
	property p_empty_hold;
		@(posedge i_clk) disable iff (i_reset)
		(empty_sync_q[1] && st_q == JFR_IDLE) |=> !o_rd_req;
	endproperty
	a_empty_hold: assert property (p_empty_hold) else $error("read while empty");
	c_deq: cover property (@(posedge i_clk) disable iff (i_reset) st_q == JFR_WAIT);
	c_drain: cover property (@(posedge i_clk) disable iff (i_reset) drn_sync_q[1] && o_rd_req);
	c_shift: cover property (@(posedge i_tck) disable iff (i_reset) i_ir == JFR_IR_DEQ && i_vs_sdr);
endmodule
`default_nettype wire

// >>> bench/jfr_host_model.sv
/*
 host model: drives virtual instruction, state indications, tck and tdi.
 assumes the block samples on tck rise and takes instructions on tck fall.
*/
`default_nettype none
module jfr_host_model
	import jfr_pkg::*;
(
	input wire logic i_tdo, // serial out of the block
	output logic o_tck, // stands low between frames
	output logic o_tdi, // serial in
	output logic [jfr_pkg::JFR_IR_W-1:0] o_ir, // virtual instruction
	output logic o_cdr, // capture-data indication
	output logic o_sdr, // shift-data indication
	output logic o_uir // update-instruction indication
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle levels at time zero
	initial begin
		{o_tck, o_tdi, o_ir, o_cdr, o_sdr, o_uir} = '0;
	end
	// one 64 ns period, signals move just after the fall
	task automatic pulse();
		#31 o_tck = 1'b1;
		#32 o_tck = 1'b0;
		#1;
	endtask
	// instruction shift only, three-bit code
	task automatic load_ir(input logic [JFR_IR_W-1:0] code);
		repeat (2) pulse();
		o_ir = code;
		o_uir = 1'b1;
		pulse();
		o_uir = 1'b0;
		pulse();
	endtask
	// capture then exactly eight shifts, tdo taken at each rise
	task automatic shift_dr(input jfr_word_t din, output jfr_word_t dout);
		o_cdr = 1'b1;
		pulse();
		o_cdr = 1'b0;
		o_sdr = 1'b1;
		for (int i = 0; i < 8; i++) begin
			o_tdi = din[i];
			#31 o_tck = 1'b1;
			#1 dout[i] = i_tdo;
			#31 o_tck = 1'b0;
			#1;
		end
		o_sdr = 1'b0;
		o_tdi = ~o_tdi; // no stale bit left on the line
	endtask
endmodule
`default_nettype wire

// >>> bench/jfr_top_tb_top.sv
/*
 testbench for the fifo readback control: fifo read side model, host model, checks.
 assumes the design files and the host model are compiled first.
*/
`default_nettype none
`define JFR_CHECK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
	$display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module jfr_top_tb_top
	import jfr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_reset, i_rd_empty, o_tdo, o_rd_req, tck, tdi, cdr, sdr, uir, take;
	logic [JFR_IR_W-1:0] ir;
	logic [JFR_IR_W-1:0] codes[4] = '{JFR_IR_DRAIN, JFR_IR_ENQ, 3'h0, 3'h7}; // bypass cases
	jfr_word_t rd_data, got, din, ex;
	jfr_word_t fifo_q[$]; // fifo contents
	jfr_word_t exp_q[$]; // words still expected out
	int num_errors = 0, check_count = 0, pops = 0, req_cycles = 0, p0, r0;
	logic [31:0] seed = 32'h5fac;
	jfr_top i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_tck(tck), .i_tdi(tdi), .i_ir(ir),
		.i_vs_cdr(cdr), .i_vs_sdr(sdr), .i_vs_uir(uir), .i_rd_empty(i_rd_empty),
		.i_rd_data(rd_data), .o_tdo(o_tdo), .o_rd_req(o_rd_req));
	jfr_host_model i_host (.i_tdo(o_tdo), .o_tck(tck), .o_tdi(tdi), .o_ir(ir), .o_cdr(cdr),
		.o_sdr(sdr), .o_uir(uir));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// bypass delays tdi by one rise; the captured zero comes out first
	function automatic logic bypass_ok(input jfr_word_t di, input jfr_word_t dq);
		return dq === {di[6:0], 1'b0};
	endfunction
	task automatic results();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// 250 MHz read clock
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	// fifo read side: a granted pop lands its word one clk later
	always begin
		@(posedge i_clk);
		if (o_rd_req === 1'b1)
			req_cycles++;
		take = (o_rd_req === 1'b1) && (fifo_q.size() > 0);
		#1;
		if (take) begin
			rd_data = fifo_q.pop_front();
			pops++;
		end
		i_rd_empty = (fifo_q.size() == 0);
	end
	// watchdog
	initial begin
		#100000;
		num_errors++;
		results();
	end
	initial begin
		i_reset = 1'b0;
		i_rd_empty = 1'b1;
		rd_data = '0;
		// raise reset off time zero so every reset process sees the edge
		#1 i_reset = 1'b1;
		repeat (5) @(posedge i_clk);
		`JFR_CHECK("tdo in reset", 1'b0, o_tdo)
		`JFR_CHECK("req in reset", 1'b0, o_rd_req)
		#1 i_reset = 1'b0;
		// corner words first, then random ones below 256
		fifo_q = '{8'h80, 8'h01, 8'hff};
		for (int n = 0; n < 4; n++) begin
			seed = lfsr(seed);
			fifo_q.push_back(seed[7:0]);
		end
		exp_q = fifo_q;
		// dequeue each of the seven words, then once more against an empty fifo
		for (int n = 0; n < 8; n++) begin
			p0 = pops;
			r0 = req_cycles;
			i_host.load_ir(JFR_IR_DEQ);
			repeat (25) @(posedge i_clk);
			`JFR_CHECK("pops per dequeue", p0 + (n < 7), pops)
			`JFR_CHECK("req pulse cycles", r0 + (n < 7), req_cycles)
			seed = lfsr(seed);
			i_host.shift_dr(seed[7:0], got);
			if (n < 7) begin
				ex = exp_q.pop_front();
				`JFR_CHECK("word out", ex, got)
			end
		end
		// drain six words with a lone instruction shift
		for (int n = 0; n < 6; n++) begin
			seed = lfsr(seed);
			fifo_q.push_back(seed[7:0]);
		end
		p0 = pops;
		r0 = req_cycles;
		i_host.load_ir(JFR_IR_DRAIN);
		for (int k = 0; k < 300 && fifo_q.size() > 0; k++)
			@(posedge i_clk);
		repeat (10) @(posedge i_clk);
		#1;
		`JFR_CHECK("drained words", p0 + 6, pops)
		`JFR_CHECK("req after empty", 1'b0, o_rd_req)
		`JFR_CHECK("drain req span", 1'b1, (req_cycles - r0) inside {[6:9]})
		// bypass under drain and other codes, no pops
		p0 = pops;
		foreach (codes[c]) begin
			i_host.load_ir(codes[c]);
			seed = lfsr(seed);
			din = seed[7:0];
			i_host.shift_dr(din, got);
			`JFR_CHECK("bypass path", 1'b1, bypass_ok(din, got))
		end
		`JFR_CHECK("pops on other codes", p0, pops)
		results();
	end
endmodule
`default_nettype wire
